/* pwm_output_start_config.sv */
`timescale 1ns/100ps
// Output stage configuration registers and two-part start sequencer.
module pwm_output_start_config
  import pwm_start_pkg::*;
#(
  parameter int UNIT_CYC = CYC_PER_100US
)
(
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Register port from the serial control interface.
  input  wire logic       regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // System control bits.
  input  wire logic       runHalt,
  input  wire logic       surroundMode,
  // Modulator request per channel and tick.
  input  wire logic       modulator_clock_tick,
  input  wire logic [5:0] pwmRequest,
  // Configuration outputs.
  output logic            first_biquadCompEn,
  output logic            toneDetectEn,
  output logic            rampStep,
  output logic      [3:0] limitTicks,
  output logic      [4:0] minWidthTicks,
  // Output stage.
  output logic      [5:0] pwmOut,
  output logic            group_one_enable,
  output logic            group_two_enable,
  output logic            chargeBusy
);
  typedef enum logic [1:0] {ST_OFF, ST_CHARGE, ST_RUN} seq_t;

  logic [7:0] volOpt_q, limit_q, startPhase_q, groupSel_q, charge_q;
  seq_t       state_q;
  logic       timerStart, timerDone;
  logic [5:0] active, enabled_q;

  // Register writes; reserved bits held at their fixed values.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      volOpt_q     <= RST_VOLUME_OPT;
      limit_q      <= RST_PULSE_LIMIT;
      startPhase_q <= RST_START_PHASE;
      groupSel_q   <= RST_GROUP_SEL;
      charge_q     <= RST_CHARGE_WAIT;
    end else if (regWrite) begin
      unique case (regAddr)
        ADDR_VOLUME_OPT:  volOpt_q     <= {1'b1, regWdata[6:5], 1'b1, 1'b0, regWdata[2:0]};
        ADDR_PULSE_LIMIT: limit_q      <= {5'h0, regWdata[2:0]};
        ADDR_START_PHASE: startPhase_q <= {2'b00, regWdata[5:0]};
        ADDR_GROUP_SEL:   groupSel_q   <= {2'b00, regWdata[5:0]};
        ADDR_CHARGE_WAIT: charge_q     <= {3'h0, regWdata[4:0]};
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    unique case (regAddr)
      ADDR_VOLUME_OPT:  regRdata = volOpt_q;
      ADDR_PULSE_LIMIT: regRdata = limit_q;
      ADDR_START_PHASE: regRdata = startPhase_q;
      ADDR_GROUP_SEL:   regRdata = groupSel_q;
      ADDR_CHARGE_WAIT: regRdata = charge_q;
      default:          regRdata = 8'h00;
    endcase
  end

  // Volume option and pulse limit fields.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      first_biquadCompEn <= 1'b0;
      toneDetectEn       <= 1'b0;
      limitTicks         <= RST_LIMIT_TICKS;
      minWidthTicks      <= RST_MIN_WIDTH;
    end else begin
      first_biquadCompEn <= volOpt_q[BIT_COMP_EN];
      toneDetectEn       <= volOpt_q[BIT_DETECT_EN];
      limitTicks         <= 4'(limit_q[2:0]) + 4'd1;
      minWidthTicks      <= 5'({limit_q[2:0], 1'b0}) + 5'd2;
    end
  end

  volume_slew volume_slew_i (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .slewCode (volOpt_q[2:0]),
    .rampStep (rampStep)
  );

  assign timerStart = (state_q == ST_OFF) && !runHalt;

  charge_timer charge_timer_i (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .start     (timerStart),
    .loadCount (charge_cycles(charge_q[4:0], UNIT_CYC)),
    .done      (timerDone)
  );

  // Start sequencer: off, charge wait, run.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_OFF;
    end else if (runHalt) begin
      state_q <= ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF:    state_q <= ST_CHARGE;
        ST_CHARGE: if (timerDone) state_q <= ST_RUN;
        ST_RUN:    state_q <= ST_RUN;
      endcase
    end
  end

  // Channels allowed in this configuration; group one only in surround.
  assign active = surroundMode ? 6'h3f : ~groupSel_q[5:0];

  // Channel enables: part-one channels during charge, all allowed channels after.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enabled_q        <= '0;
      group_one_enable <= 1'b0;
      group_two_enable <= 1'b0;
    end else begin
      unique case (state_q)
        ST_OFF:    enabled_q <= '0;
        ST_CHARGE: enabled_q <= active & startPhase_q[5:0];
        ST_RUN:    enabled_q <= active;
      endcase
      group_one_enable <= (state_q != ST_OFF) && !runHalt && surroundMode;
      group_two_enable <= (state_q != ST_OFF) && !runHalt;
    end
  end

  // Output drive: a held-off channel stays low.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmOut <= '0;
    end else if (modulator_clock_tick) begin
      pwmOut <= pwmRequest & enabled_q;
    end else begin
      pwmOut <= pwmOut & enabled_q; // Drops disabled channels even without a tick.
    end
  end

  assign chargeBusy = (state_q == ST_CHARGE);

  // Checker helpers: cycles spent in the charge wait and the length loaded for it.
  logic [31:0] chargeCnt_q;
  logic [31:0] chargeLoad_q;

  // Counts cycles in the charge state; any other state clears the count.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chargeCnt_q <= '0;
    end else if (state_q != ST_CHARGE) begin
      chargeCnt_q <= '0;
    end else begin
      chargeCnt_q <= chargeCnt_q + 32'd1;
    end
  end

  // Captures the programmed wait when a start request is taken.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chargeLoad_q <= '0;
    end else if (timerStart) begin
      chargeLoad_q <= charge_cycles(charge_q[4:0], UNIT_CYC);
    end
  end

  // A start request taken while the sequencer is off.
  sequence s_start_req;
    state_q == ST_OFF && !runHalt;
  endsequence

  // The charge wait ending and the run state beginning on the next edge.
  sequence s_charge_exit;
    state_q == ST_CHARGE ##1 state_q == ST_RUN;
  endsequence

  // Shutting down drops both group enables on the next edge.
  a_halt_groups_low: assert property (@(posedge ref_clk) disable iff (srst)
    runHalt |=> !group_one_enable && !group_two_enable)
    else $error("groups not off on halt");

  // A steady reduced configuration keeps group one disabled.
  a_reduced_group_one: assert property (@(posedge ref_clk) disable iff (srst)
    !surroundMode && $stable(surroundMode) |=> !group_one_enable)
    else $error("group one on in reduced mode");

  // The limit output is the code plus one, one cycle after the register.
  a_limit_ticks: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 limitTicks == 4'($past(limit_q[2:0])) + 4'd1)
    else $error("limit ticks wrong");

  // The minimum width is always twice the limit.
  a_min_width: assert property (@(posedge ref_clk) disable iff (srst)
    minWidthTicks == 5'({limitTicks, 1'b0}))
    else $error("min width mismatch");

  // Reserved volume bits read as ones and the unused bit as zero.
  a_reserved_ones: assert property (@(posedge ref_clk) disable iff (srst)
    volOpt_q[7] && volOpt_q[4] && !volOpt_q[3])
    else $error("reserved volume bits wrong");

  // Compensation enable follows its register bit with one cycle of latency.
  a_comp_follow: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 first_biquadCompEn == $past(volOpt_q[6]))
    else $error("compensation enable wrong");

  // Detection enable follows its register bit with one cycle of latency.
  a_detect_follow: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 toneDetectEn == $past(volOpt_q[5]))
    else $error("detect enable wrong");

  // Part-two channels stay off through the charge wait.
  a_charge_hold: assert property (@(posedge ref_clk) disable iff (srst)
    state_q == ST_CHARGE && !runHalt |=> (enabled_q & ~startPhase_q[5:0]) == 6'h00)
    else $error("part two early");

  // No output switches unless its channel was enabled.
  a_group_mask: assert property (@(posedge ref_clk) disable iff (srst)
    (pwmOut & ~enabled_q & ~$past(enabled_q)) == 6'h00)
    else $error("disabled channel driven");

  // With no charge period the run state follows the start after a single charge cycle.
  a_no_wait_run: assert property (@(posedge ref_clk) disable iff (srst)
    s_start_req ##0 charge_q[4:3] == 2'b00 ##1 !runHalt |=> state_q == ST_RUN)
    else $error("no-wait start not immediate");

  // A start request always enters the charge wait first.
  a_start_charge: assert property (@(posedge ref_clk) disable iff (srst)
    s_start_req |=> state_q == ST_CHARGE && chargeBusy)
    else $error("start skipped charge state");

  // Part two is released only once the timer has expired.
  a_exit_after_wait: assert property (@(posedge ref_clk) disable iff (srst)
    s_charge_exit |-> $past(timerDone))
    else $error("run before wait expired");

  // The charge wait lasts one cycle more than the loaded number of cycles.
  a_charge_length: assert property (@(posedge ref_clk) disable iff (srst)
    s_charge_exit |-> $past(chargeCnt_q) == chargeLoad_q)
    else $error("charge wait length wrong");

  // A sequencer held off keeps every channel and both groups disabled.
  a_off_outputs_low: assert property (@(posedge ref_clk) disable iff (srst)
    state_q == ST_OFF ##1 state_q == ST_OFF |-> enabled_q == 6'h00 && !group_one_enable && !group_two_enable)
    else $error("outputs enabled while off");

  // Group two runs whenever the system is started.
  a_group_two_run: assert property (@(posedge ref_clk) disable iff (srst)
    state_q != ST_OFF && !runHalt |=> group_two_enable)
    else $error("group two not enabled");

  // Group one runs whenever the system is started with every channel configured to switch.
  a_group_one_surround: assert property (@(posedge ref_clk) disable iff (srst)
    state_q != ST_OFF && !runHalt && surroundMode |=> group_one_enable)
    else $error("group one not enabled");

  // In reduced mode no group-one channel is enabled.
  a_reduced_channels: assert property (@(posedge ref_clk) disable iff (srst)
    !surroundMode |=> (enabled_q & $past(groupSel_q[5:0])) == 6'h00)
    else $error("group one channel enabled in reduced mode");

  // After the wait every channel runs when all are configured.
  a_run_all_active: assert property (@(posedge ref_clk) disable iff (srst)
    state_q == ST_RUN && surroundMode |=> enabled_q == 6'h3f)
    else $error("channels missing after wait");

  // A modulator tick passes the enabled requests to the outputs.
  a_tick_follow: assert property (@(posedge ref_clk) disable iff (srst)
    modulator_clock_tick |=> pwmOut == $past(pwmRequest & enabled_q))
    else $error("outputs do not follow tick");

  // Without a tick no output may rise.
  a_no_tick_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !modulator_clock_tick |=> (pwmOut & ~$past(pwmOut)) == 6'h00)
    else $error("output rose without tick");

  // A ramp step lasts a single cycle.
  a_ramp_single: assert property (@(posedge ref_clk) disable iff (srst)
    rampStep |=> !rampStep)
    else $error("ramp step too long");

  // A limit write keeps only the three code bits.
  a_limit_write: assert property (@(posedge ref_clk) disable iff (srst)
    regWrite && regAddr == ADDR_PULSE_LIMIT |=> limit_q == {5'h00, $past(regWdata[2:0])})
    else $error("limit write wrong");

  // A charge write keeps only the five code bits.
  a_charge_write: assert property (@(posedge ref_clk) disable iff (srst)
    regWrite && regAddr == ADDR_CHARGE_WAIT |=> charge_q == {3'h0, $past(regWdata[4:0])})
    else $error("charge write wrong");

  // A start phase write keeps the six channel bits.
  a_start_write: assert property (@(posedge ref_clk) disable iff (srst)
    regWrite && regAddr == ADDR_START_PHASE |=> startPhase_q == {2'b00, $past(regWdata[5:0])})
    else $error("start phase write wrong");

  // A group select write keeps the six channel bits.
  a_group_write: assert property (@(posedge ref_clk) disable iff (srst)
    regWrite && regAddr == ADDR_GROUP_SEL |=> groupSel_q == {2'b00, $past(regWdata[5:0])})
    else $error("group select write wrong");
endmodule // pwm_output_start_config

/* pwm_start_pkg.sv */
// Package with register map, reset values and timing constants for the output start block.
// Overview of operation
// - Volume bit 6 enables first biquad compensation.
// - Volume bit 5 enables automatic 38 kHz detection.
// - Volume bits 2:0 select slew rate.
// - Limit code N gives N+1, 2(N+1) ticks.
// - Start bit set: channel runs in part one.
// - Group-select bit set puts channel in group one.
// - Reduced configuration drives group-one enable low.
// - Wait charge period before starting PWM.
// - Five-bit code selects no wait or period.
// - Run bit set shuts down, clear starts.
// - Configuration bit chooses both groups or group two.
package pwm_start_pkg;
  localparam logic [7:0] ADDR_VOLUME_OPT  = 8'h0e;
  localparam logic [7:0] ADDR_PULSE_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_START_PHASE = 8'h18;
  localparam logic [7:0] ADDR_GROUP_SEL   = 8'h19;
  localparam logic [7:0] ADDR_CHARGE_WAIT = 8'h1a;
  localparam logic [7:0] RST_VOLUME_OPT   = 8'h90;
  localparam logic [7:0] RST_PULSE_LIMIT  = 8'h00;
  localparam logic [7:0] RST_START_PHASE  = 8'h3f;
  localparam logic [7:0] RST_GROUP_SEL    = 8'h00;
  localparam logic [7:0] RST_CHARGE_WAIT  = 8'h00;
  localparam logic [3:0] RST_LIMIT_TICKS  = 4'h1;
  localparam logic [4:0] RST_MIN_WIDTH    = 5'h02;
  localparam int BIT_COMP_EN   = 6;
  localparam int BIT_DETECT_EN = 5;
  localparam int CLK_HZ        = 40_000_000;
  localparam int CYC_PER_100US = (CLK_HZ / 10_000);
  // Charge periods in units of 0.1 ms, codes 01000 to 11111.
  localparam int CHARGE_TENTHS_MS [0:23] = '{130, 169, 234, 312, 416, 546, 728, 962,
    1300, 1560, 2340, 3120, 4160, 5460, 7280, 9620,
    13000, 16900, 23400, 31200, 41600, 54600, 72800, 96200};
  localparam int SLEW_BASE_CYC = 64;
  function automatic logic [31:0] charge_cycles(input logic [4:0] code, input int unitCyc);
    logic [31:0] idx;
    idx = 32'(code) - 32'd8;
    charge_cycles = (code[4:3] == 2'b00) ? 32'd0 : 32'(CHARGE_TENTHS_MS[idx] * unitCyc);
  endfunction
endpackage

/* charge_timer.sv */
`timescale 1ns/100ps
// Charge wait timer that counts down a programmed number of cycles.
module charge_timer
  import pwm_start_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Control.
  input  wire logic        start,
  input  wire logic [31:0] loadCount,
  // Status.
  output logic             done
);
  logic [31:0] count_q;

  // Load on start, then count down to zero.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (start) begin
      count_q <= loadCount;
    end else if (count_q != 32'd0) begin
      count_q <= count_q - 32'd1;
    end
  end

  assign done = (count_q == 32'd0) && !start;
endmodule // charge_timer

/* volume_slew.sv */
`timescale 1ns/100ps
// Volume ramp pacing: a tick whose spacing grows with the slew code.
module volume_slew
  import pwm_start_pkg::*;
(
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Setting.
  input  wire logic [2:0] slewCode,
  // Ramp step strobe.
  output logic            rampStep
);
  logic [15:0] div_q;
  logic [15:0] span;

  // Span doubles for each code step, so larger codes ramp slower.
  assign span = 16'(SLEW_BASE_CYC << slewCode);

  // Free-running divider producing a one-cycle step.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q    <= '0;
      rampStep <= 1'b0;
    end else if (div_q >= span - 16'd1) begin
      div_q    <= '0;
      rampStep <= 1'b1;
    end else begin
      div_q    <= div_q + 16'd1;
      rampStep <= 1'b0;
    end
  end
endmodule // volume_slew

/* power_stage_model.sv */
// Power stage model that follows the group enables and the PWM lines.
`timescale 1ns/100ps
module power_stage_model (
  // Drive from the block.
  input  wire logic [5:0] pwmIn,
  input  wire logic       grpOneEn,
  input  wire logic       grpTwoEn,
  input  wire logic [5:0] grpSel,
  // Speaker side, high impedance while a stage is held in reset.
  output logic      [5:0] spkOut
);
  // A stage switches only while the enable of its group is high.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      spkOut[i] = (grpSel[i] ? grpOneEn : grpTwoEn) ? pwmIn[i] : 1'bz;
    end
  end
endmodule // power_stage_model

/* pwm_output_start_config_tb_top.sv */
// Self-checking testbench for the output start configuration block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module pwm_output_start_config_tb_top
  import pwm_start_pkg::*;
;
  logic       ref_clk, regWrite = 0, runHalt = 1, srst = 1, surroundMode = 1, tick = 1;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, d;
  logic [5:0] pwmRequest = 0, pwmOut, spk, sp, gs, r, e;
  logic       bqEn, detEn, rampStep, g1, g2, busy;
  logic [3:0] limitTicks;
  logic [4:0] minWidthTicks;
  int         mismatches = 0, n_compared = 0, n;
  localparam int UNIT_CYC_SIM = 1;

  pwm_output_start_config #(.UNIT_CYC(UNIT_CYC_SIM)) pwm_output_start_config_i (.ref_clk(ref_clk), .srst(srst),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .runHalt(runHalt),
    .surroundMode(surroundMode), .modulator_clock_tick(tick), .pwmRequest(pwmRequest),
    .first_biquadCompEn(bqEn), .toneDetectEn(detEn), .rampStep(rampStep), .limitTicks(limitTicks),
    .minWidthTicks(minWidthTicks), .pwmOut(pwmOut), .group_one_enable(g1), .group_two_enable(g2),
    .chargeBusy(busy));
  power_stage_model power_stage_model_i (.pwmIn(pwmOut), .grpOneEn(g1), .grpTwoEn(g2), .grpSel(gs),
    .spkOut(spk));

  // Clock at 40 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Expected volume readback: reserved bits one, unused bit zero.
  function automatic logic [7:0] vol_expect(input logic [7:0] v);
    return (v | 8'h90) & 8'hf7;
  endfunction
  // Expected charge wait in cycles for a charge code.
  function automatic int wait_cycles(input int code);
    return (code < 8) ? 0 : CHARGE_TENTHS_MS[code - 8] * UNIT_CYC_SIM;
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    regAddr <= a;
    #1;
    `CHK("regRdata", x, regRdata)
  endtask
  // Waits out one ramp step, then counts the cycles to the next one.
  task automatic gap(output int c);
    c = 0;
    while (rampStep !== 1'b1 && c < 3000) begin cyc(1); c++; end
    c = 0;
    do begin cyc(1); c++; end while (rampStep !== 1'b1 && c < 3000);
  endtask

  // Watchdog in case the block hangs.
  initial begin
    #(25 * 40000);
    mismatches++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h91d6));
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rd(ADDR_VOLUME_OPT, RST_VOLUME_OPT);
    rd(ADDR_PULSE_LIMIT, RST_PULSE_LIMIT);
    rd(ADDR_START_PHASE, RST_START_PHASE);
    rd(ADDR_GROUP_SEL, RST_GROUP_SEL);
    rd(ADDR_CHARGE_WAIT, RST_CHARGE_WAIT);
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h90 : (8'($urandom) | 8'h90);
      wr(ADDR_VOLUME_OPT, d);
      rd(ADDR_VOLUME_OPT, vol_expect(d));
      `CHK("first_biquadCompEn", d[6], bqEn)
      `CHK("toneDetectEn", d[5], detEn)
    end
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_PULSE_LIMIT, 8'(k) | 8'hf8);
      rd(ADDR_PULSE_LIMIT, 8'(k));
      `CHK("limitTicks", 4'(k + 1), limitTicks)
      `CHK("minWidthTicks", 5'(2 * k + 2), minWidthTicks)
    end
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_VOLUME_OPT, 8'h90 | 8'(s));
      gap(n);
      gap(n);
      `CHK("ramp gap", 64 << s, n)
    end
    // Split-capacitor start with every channel, then shut down.
    for (int k = 0; k < 2; k++) begin
      gs = 6'($urandom);
      sp = (k == 0) ? 6'h3f : (6'($urandom) | 6'h01);
      r = 6'($urandom) | 6'h21;
      pwmRequest <= r;
      tick <= 1'b1;
      wr(ADDR_START_PHASE, {2'b00, sp});
      wr(ADDR_GROUP_SEL, {2'b11, gs});
      wr(ADDR_CHARGE_WAIT, 8'h08 + 8'(k));
      rd(ADDR_START_PHASE, {2'b00, sp});
      runHalt <= 1'b0;
      cyc(4);
      `CHK("pwmOut part one", sp & r, pwmOut)
      `CHK("group enables", 2'b11, {g1, g2})
      `CHK("chargeBusy", 1'b1, busy)
      n = 4;
      while (busy === 1'b1 && n < 1000) begin cyc(1); n++; end
      `CHK("charge length", 1'b1, n >= wait_cycles(8 + k) && n <= wait_cycles(8 + k) + 5)
      cyc(2);
      `CHK("pwmOut part two", r, pwmOut)
      tick <= 1'(k);
      pwmRequest <= ~r;
      cyc(2);
      `CHK("pwmOut tick gate", (k == 0) ? r : ~r, pwmOut)
      runHalt <= 1'b1;
      cyc(3);
      `CHK("halted enables", 3'b000, {g1, g2, |pwmOut})
      `CHK("stage off", 6'bzzzzzz, spk)
    end
    // Reduced configuration with no charge wait, changed while shut down.
    pwmRequest <= r;
    surroundMode <= 1'b0;
    wr(ADDR_CHARGE_WAIT, 8'h07);
    runHalt <= 1'b0;
    cyc(4);
    `CHK("reduced enables", 3'b010, {g1, g2, busy})
    `CHK("reduced pwmOut", r & ~gs, pwmOut)
    for (int i = 0; i < 6; i++) e[i] = gs[i] ? 1'bz : r[i];
    `CHK("stage out", e, spk)
    print_verdict();
  end
endmodule // pwm_output_start_config_tb_top
